// ### inc/smcs_map.svh
// offsets, field positions, reset values and timing counts of the slave
`ifndef SMCS_MAP_SVH
`define SMCS_MAP_SVH

// command codes
`define SMCS_CMD_LATCH_SET   8'h06
`define SMCS_CMD_LATCH_CLEAR 8'h04
`define SMCS_CMD_STATUS_READ 8'h05
`define SMCS_CMD_STATUS_WR   8'h01
`define SMCS_CMD_READ        8'h03
`define SMCS_CMD_WRITE       8'h02
`define SMCS_CMD_SLEEP       8'hb9
`define SMCS_CMD_WAKE        8'hab

// protection_status_reg fields
`define SMCS_SR_RESET        8'h00
`define SMCS_SR_LOCK_BIT     7
`define SMCS_SR_BP_HI_BIT    3
`define SMCS_SR_BP_LO_BIT    2
`define SMCS_SR_WEL_BIT      1
`define SMCS_SR_WEL_MASK     8'h02

// array geometry and write buffer depth
`define SMCS_ADDR_W          19
`define SMCS_ADDR_BYTES      2'h3
`define SMCS_FIFO_DEPTH      8

// pin sampler bit positions, all stored active high
`define SMCS_PIN_CS          4
`define SMCS_PIN_SCK         3
`define SMCS_PIN_SI          2
`define SMCS_PIN_WP_LO       1
`define SMCS_PIN_HOLD        0

// wake recovery time and its cycle count at the reference clock
`define SMCS_CLK_MHZ         25
`define SMCS_WAKE_NS         1000
`define SMCS_WAKE_W          8
`define SMCS_WAKE_CYC ((`SMCS_WAKE_NS * `SMCS_CLK_MHZ + 999) / 1000)

`endif

// ### inc/smcs_pkg.sv
// types shared by the serial command slave and its write buffer
package smcs_pkg;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CMD,
        PH_ADDR,
        PH_WDATA,
        PH_RDATA,
        PH_RSTAT,
        PH_WSTAT,
        PH_SKIP
    } smcs_phase_t;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0]  data;
    } smcs_wr_t;

    typedef struct packed {
        logic [4:0]  s1;        // first sampler stage
        logic [4:0]  s2;        // second sampler stage
        logic        sck_prev;
        logic        cs_prev;
        smcs_phase_t ph;
        logic [2:0]  bitcnt;
        logic [1:0]  abyte;
        logic [7:0]  rx;
        logic [7:0]  tx;
        logic [7:0]  cmd;
        logic [18:0] addr;
        logic [7:0]  sr;
        logic        mode3;
        logic        hw_lock;
        logic        asleep;
        logic        wake_req;
        logic [7:0]  wake_cnt;
        logic        rd_pend;
        logic [7:0]  rd_buf;
        logic        so;
        logic        so_oe;
        logic        mem_re;
        logic [18:0] mem_raddr;
        logic        mem_we;
        smcs_wr_t    mem_w;
        logic        push;
        smcs_wr_t    push_w;
        logic        wbuf_rdy;
        logic        overrun;
    } smcs_core_t;

endpackage

// ### rtl/smcs_slave.sv
// serial command slave of a byte-wide nonvolatile ram, with write buffer
//
// How it works
// - modes 0/3, sample rising, shift falling
// - clock level at select fall picks mode
// - one command per select low period
// - status: lock, two protect bits, latch
// - status bits start at zero
// - latch gates array, status writes; lock gates status writes
// - protect bits pick none/quarter/half/all
// - write-protect low with lock set keeps protect bits locked
// - write-protect high: software protection only
// - status read whenever awake and recovered, no busy bit
// - latch set command sets latch
// - latch clear command clears latch
// - latch clears at power-up, clear command
// - status write only when allowed
// - status kept over power, latch cleared
// - read decodes 19 bits, streams bytes
// - address counter wraps to zero
// - write stores bytes at full rate
// - asleep, only wake command accepted
// - power loss while asleep wakes up
// - select high: ignore inputs, output off
// - hold low suspends, floats output
// - wake recovery before next command
`timescale 1ns/100ps

`include "smcs_map.svh"

module smcs_fifo
    import smcs_pkg::*;
#(
    parameter int W     = 27,
    parameter int DEPTH = `SMCS_FIFO_DEPTH
) (
    input  wire logic         ref_clk,   // reference clock
    input  wire logic         rst_n,     // synchronous reset, active low
    input  wire logic         ce,        // clock enable
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // word available
    input  wire logic         out_ready, // sink takes the word
    output logic [W-1:0]      out_data   // word out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } smcs_fifo_st_t;

    smcs_fifo_st_t q;
    smcs_fifo_st_t d;
    logic          full;
    logic          empty;

    // one extra pointer bit tells full from empty
    assign full      = (q.wp[AW] != q.rp[AW]) &&
                       (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty     = (q.wp == q.rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = q.mem[q.rp[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid && !full) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule // smcs_fifo

module smcs_slave
    import smcs_pkg::*;
(
    input  wire logic        ref_clk,     // 25 MHz reference clock
    input  wire logic        rst_n,       // synchronous reset, factory state
    input  wire logic        ce,          // clock enable, freezes all state
    input  wire logic        pwr_up,      // one-cycle power-restore pulse
    input  wire logic        cs_n,        // chip select pin, active low
    input  wire logic        sck,         // serial clock pin
    input  wire logic        si,          // serial data in pin
    input  wire logic        wp_n,        // write-protect pin, active low
    input  wire logic        hold_n,      // hold pin, active low
    output logic             so,          // serial data out
    output logic             so_oe,       // serial out driven
    output logic             mem_re,      // array read strobe
    output logic [18:0]      mem_raddr,   // array read address
    input  wire logic        mem_rvalid,  // array read data valid
    input  wire logic [7:0]  mem_rdata,   // array read data
    output logic             mem_we,      // array write strobe
    output logic [18:0]      mem_waddr,   // array write address
    output logic [7:0]       mem_wdata,   // array write data
    input  wire logic        mem_ready,   // array takes the write
    output logic [7:0]       status,      // protection_status_reg
    output logic             mode3,       // mode 3 detected at select
    output logic             asleep,      // sleep mode
    output logic             wbuf_ready,  // write buffer has room
    output logic             wr_overrun   // sticky: write byte lost
);
    smcs_core_t q;
    smcs_core_t d;

    logic       f_in_ready;
    logic       f_out_valid;
    logic       f_out_ready;
    smcs_wr_t   f_out_data;

    function automatic logic blk_prot(input logic [18:0] a,
                                      input logic [1:0] bp);
        case (bp)
            2'h0:    blk_prot = 1'b0;
            2'h1:    blk_prot = (a[18:17] == 2'h3);
            2'h2:    blk_prot = a[18];
            default: blk_prot = 1'b1;
        endcase
    endfunction

    // buffer lets bytes land at full serial rate while the array stalls;
    // a ninth word waits in the write stage
    smcs_fifo #(
        .W     ($bits(smcs_wr_t)),
        .DEPTH (`SMCS_FIFO_DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (q.push),
        .in_ready  (f_in_ready),
        .in_data   (q.push_w),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // the write stage may reload whenever it is empty or being taken
    assign f_out_ready = !q.mem_we || mem_ready;

    always_comb begin
        logic        cs_act;
        logic        sck_lv;
        logic        hold_act;
        logic        rise;
        logic        fall;
        logic        cs_fall;
        logic        cs_rise;
        logic [7:0]  rx_n;
        logic [7:0]  byte_o;
        logic [1:0]  bp;
        logic        sr_wr_ok;
        cs_fall  = 1'b0;
        cs_rise  = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        sr_wr_ok = 1'b0;
        cs_act   = q.s2[`SMCS_PIN_CS];
        sck_lv   = q.s2[`SMCS_PIN_SCK];
        hold_act = q.s2[`SMCS_PIN_HOLD];
        rx_n     = {q.rx[6:0], q.s2[`SMCS_PIN_SI]};
        byte_o   = 8'h00;
        bp       = {q.sr[`SMCS_SR_BP_HI_BIT], q.sr[`SMCS_SR_BP_LO_BIT]};
        d        = q;

        // pins pass two flops; only s2 is looked at
        d.s1 = {~cs_n, sck, si, ~wp_n, ~hold_n};
        d.s2 = q.s1;
        d.sck_prev = sck_lv;
        d.push = 1'b0;

        // hold freezes select tracking so its edges are seen afterwards
        if (!hold_act) begin
            d.cs_prev = cs_act;
        end
        cs_fall = !hold_act && cs_act && !q.cs_prev;
        cs_rise = !hold_act && !cs_act && q.cs_prev;
        // clock edges count only once select has been seen low twice
        rise = !hold_act && cs_act && q.cs_prev &&
               sck_lv && !q.sck_prev;
        fall = !hold_act && cs_act && q.cs_prev &&
               !sck_lv && q.sck_prev;

        // hardware protection entered while pin low and lock set
        if (!q.s2[`SMCS_PIN_WP_LO]) begin
            d.hw_lock = 1'b0;
        end else if (q.sr[`SMCS_SR_LOCK_BIT]) begin
            d.hw_lock = 1'b1;
        end
        sr_wr_ok = q.sr[`SMCS_SR_WEL_BIT] && !q.hw_lock &&
                   !(q.sr[`SMCS_SR_LOCK_BIT] && q.s2[`SMCS_PIN_WP_LO]);

        // commands are ignored until the recovery count runs out
        if (q.wake_cnt != 8'h00) begin
            d.wake_cnt = q.wake_cnt - 8'h01;
        end

        if (cs_fall) begin
            d.mode3  = sck_lv;
            d.ph     = PH_CMD;
            d.bitcnt = 3'h0;
            d.abyte  = 2'h0;
            d.wake_req = 1'b0;
        end else if (cs_rise) begin
            d.ph = PH_IDLE;
            d.rd_pend = 1'b0;
            // wake takes effect only when its frame is closed
            if (q.wake_req) begin
                d.asleep   = 1'b0;
                d.wake_cnt = 8'(`SMCS_WAKE_CYC);
                d.wake_req = 1'b0;
            end
        end else if (rise) begin
            d.rx     = rx_n;
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == 3'h7) begin
                case (q.ph)
                    PH_CMD: begin
                        d.cmd = rx_n;
                        d.ph  = PH_SKIP;
                        if (q.asleep || q.wake_cnt != 8'h00) begin
                            // a sleeping part hears only the wake code
                            d.wake_req = q.asleep &&
                                         (rx_n == `SMCS_CMD_WAKE);
                        end else begin
                            case (rx_n)
                                `SMCS_CMD_LATCH_SET:
                                    d.sr[`SMCS_SR_WEL_BIT] = 1'b1;
                                `SMCS_CMD_LATCH_CLEAR:
                                    d.sr[`SMCS_SR_WEL_BIT] = 1'b0;
                                `SMCS_CMD_STATUS_READ:
                                    d.ph = PH_RSTAT;
                                `SMCS_CMD_STATUS_WR:
                                    d.ph = PH_WSTAT;
                                `SMCS_CMD_READ,
                                `SMCS_CMD_WRITE:
                                    d.ph = PH_ADDR;
                                `SMCS_CMD_SLEEP:
                                    d.asleep = 1'b1;
                                default:
                                    d.ph = PH_SKIP;
                            endcase
                        end
                    end
                    PH_ADDR: begin
                        // upper address bits fall off the top
                        d.addr  = {q.addr[10:0], rx_n};
                        d.abyte = q.abyte + 2'h1;
                        if (q.abyte == (`SMCS_ADDR_BYTES - 2'h1)) begin
                            if (q.cmd == `SMCS_CMD_READ) begin
                                d.ph      = PH_RDATA;
                                d.rd_pend = 1'b1;
                            end else begin
                                d.ph = PH_WDATA;
                            end
                        end
                    end
                    PH_WDATA: begin
                        if (q.sr[`SMCS_SR_WEL_BIT] &&
                            !blk_prot(q.addr, bp)) begin
                            d.push        = 1'b1;
                            d.push_w.addr = q.addr;
                            d.push_w.data = rx_n;
                            if (!f_in_ready) begin
                                d.overrun = 1'b1;
                            end
                        end
                        // refused bytes still step the address
                        d.addr = q.addr + 19'h1;
                    end
                    PH_WSTAT: begin
                        if (sr_wr_ok) begin
                            // latch bit is not loaded by the data byte
                            d.sr = (rx_n & ~`SMCS_SR_WEL_MASK) |
                                   (q.sr & `SMCS_SR_WEL_MASK);
                        end
                        d.ph = PH_SKIP;
                    end
                    default: begin
                        d.ph = q.ph;
                    end
                endcase
            end
        end else if (fall) begin
            // a new byte starts when the bit counter has wrapped
            if (q.bitcnt == 3'h0 &&
                (q.ph == PH_RDATA || q.ph == PH_RSTAT)) begin
                if (q.ph == PH_RSTAT) begin
                    byte_o = q.sr;
                end else begin
                    byte_o    = q.rd_buf;
                    d.addr    = q.addr + 19'h1;
                    d.rd_pend = 1'b1;
                end
                d.so = byte_o[7];
                d.tx = {byte_o[6:0], 1'b0};
            end else begin
                d.so = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
            end
        end

        // output driven only for reads with select low and hold off
        d.so_oe = cs_act && !hold_act &&
                  (q.ph == PH_RDATA || q.ph == PH_RSTAT);

        // array read waits for buffered writes so it sees fresh data
        d.mem_re = 1'b0;
        if (q.rd_pend && !d.mem_re && !q.mem_re && !q.push &&
            !f_out_valid && !q.mem_we) begin
            d.mem_re    = 1'b1;
            d.mem_raddr = q.addr;
            d.rd_pend   = 1'b0;
        end
        // data must be back before the next byte's first fall
        if (mem_rvalid) begin
            d.rd_buf = mem_rdata;
        end

        // write stage toward the array
        if (f_out_ready) begin
            d.mem_we = f_out_valid;
            d.mem_w  = f_out_data;
        end
        d.wbuf_rdy = f_in_ready;

        // power restore: latch clear, standby rather than sleep
        if (pwr_up) begin
            // other status bits are nonvolatile and kept
            d.sr[`SMCS_SR_WEL_BIT] = 1'b0;
            d.asleep   = 1'b0;
            d.wake_req = 1'b0;
            d.wake_cnt = 8'h00;
            d.ph       = PH_IDLE;
            d.rd_pend  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // registered copies only, no logic after the flops
    assign so         = q.so;
    assign so_oe      = q.so_oe;
    assign mem_re     = q.mem_re;
    assign mem_raddr  = q.mem_raddr;
    assign mem_we     = q.mem_we;
    assign mem_waddr  = q.mem_w.addr;
    assign mem_wdata  = q.mem_w.data;
    assign status     = q.sr;
    assign mode3      = q.mode3;
    assign asleep     = q.asleep;
    assign wbuf_ready = q.wbuf_rdy;
    assign wr_overrun = q.overrun;
endmodule // smcs_slave

// ### sim/smcs_slave_properties.sv
// assertion checker watching the serial command slave ports
`timescale 1ns/100ps

module smcs_slave_properties
    import smcs_pkg::*;
(
    input wire logic        ref_clk,    // reference clock
    input wire logic        rst_n,      // synchronous reset
    input wire logic        pwr_up,     // power restore pulse
    input wire logic        cs_n,       // chip select pin
    input wire logic        sck,        // serial clock pin
    input wire logic        hold_n,     // hold pin
    input wire logic        so,         // serial data out
    input wire logic        so_oe,      // serial out driven
    input wire logic        mem_re,     // array read strobe
    input wire logic        mem_we,     // array write strobe
    input wire logic [18:0] mem_waddr,  // array write address
    input wire logic [7:0]  mem_wdata,  // array write data
    input wire logic        mem_ready,  // array takes write
    input wire logic [7:0]  status,     // status register
    input wire logic        mode3,      // mode 3 detected
    input wire logic        asleep      // sleep mode
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic prot(logic [1:0] bp, logic [18:0] a);
        return (bp == 2'h3) || (bp == 2'h2 && a[18])
            || (bp == 2'h1 && a[18:17] == 2'h3);
    endfunction

    a_idle_quiet: assert property (cs_n [*4] |-> !so_oe)
        else $error("serial out driven while deselected");
    a_hold_float: assert property (!hold_n [*4] |-> !so_oe)
        else $error("serial out driven during hold");
    a_mode_pick: assert property (
        $fell(cs_n) && hold_n && !asleep |-> ##5 mode3 == $past(sck, 5))
        else $error("mode not taken from clock level");
    // changes at cs rise are excluded, mode 3 idles high there
    a_shift_fall: assert property (
        so_oe && $past(so_oe) && $changed(so) && !$past(cs_n, 3)
        |-> !$past(sck, 2))
        else $error("serial out changed away from a falling clock");
    a_status_zero: assert property (
        $rose(rst_n) |-> status == 8'h00 && !asleep)
        else $error("status not zero after reset");
    a_wr_hold: assert property (
        mem_we && !mem_ready |=> mem_we && $stable(mem_waddr)
        && $stable(mem_wdata))
        else $error("write request dropped before taken");
    a_wr_protect: assert property (
        mem_we && mem_ready |-> status[1] && !prot(status[3:2], mem_waddr))
        else $error("write into a protected place");
    a_pwr_keep: assert property (
        pwr_up && cs_n |=> !status[1] && !asleep
        && (status & 8'hfd) == ($past(status) & 8'hfd))
        else $error("power restore handled wrongly");
    a_sleep_freeze: assert property (
        asleep && !pwr_up |=> $stable(status) && !mem_re)
        else $error("activity while asleep");

    c_read_out: cover property (so_oe && !cs_n);
    c_mode3: cover property ($rose(mode3));
    c_stall: cover property (mem_we && !mem_ready);
    c_sleep: cover property ($rose(asleep));
endmodule // smcs_slave_properties

bind smcs_slave smcs_slave_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .pwr_up(pwr_up), .cs_n(cs_n),
    .sck(sck), .hold_n(hold_n), .so(so), .so_oe(so_oe),
    .mem_re(mem_re), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .status(status),
    .mode3(mode3), .asleep(asleep)
);

// ### sim/smcs_host_model.sv
// spi host model driving the slave pins in mode 0 or mode 3
`timescale 1ns/100ps

module smcs_host_model (
    input wire logic ref_clk, // reference clock
    output logic     cs_n,    // chip select, active low
    output logic     sck,     // serial clock
    output logic     si,      // serial data to slave
    output logic     hold_n   // hold, active low
);
    localparam int HALF = 5;  // slave needs 4 ref cycles per phase

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    // hb: byte index before which hold is pulsed, out of range for none
    task automatic frame(input logic m3, input logic [7:0] b[$],
                         input int hb);
        int i;
        int k;
        @(negedge ref_clk);
        sck = m3;
        repeat (HALF) @(negedge ref_clk);
        cs_n = 1'b0;
        repeat (HALF) @(negedge ref_clk);
        for (i = 0; i < b.size(); i++) begin
            if (i == hb) begin
                hold_n = 1'b0;
                repeat (4 * HALF) @(negedge ref_clk);
                hold_n = 1'b1;
                repeat (HALF) @(negedge ref_clk);
            end
            for (k = 7; k >= 0; k--) begin
                sck = 1'b0;
                si = b[i][k];
                repeat (HALF) @(negedge ref_clk);
                sck = 1'b1;
                repeat (HALF) @(negedge ref_clk);
            end
        end
        sck = m3;
        repeat (HALF) @(negedge ref_clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (2 * HALF) @(negedge ref_clk);
    endtask
endmodule // smcs_host_model

// ### sim/smcs_slave_test.sv
// self-checking bench of the serial command slave
`timescale 1ns/100ps
`include "smcs_map.svh"

module smcs_slave_test;
    import smcs_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pwr_up = 1'b0;
    logic        wp_n = 1'b1;
    logic        mem_rvalid = 1'b0;
    logic [7:0]  mem_rdata = 8'h00;
    logic        mem_ready = 1'b1;
    logic        stall = 1'b0;
    logic        ce = 1'b1;
    logic        cs_n, sck, si, hold_n, so, so_oe, mem_re, mem_we, sck_q;
    logic        mode3, asleep, wbuf_ready, wr_overrun;
    logic [18:0] mem_raddr, mem_waddr;
    logic [7:0]  mem_wdata, status, rx;
    logic [7:0]  mem [logic [18:0]];
    logic [7:0]  shad [logic [18:0]];
    logic [7:0]  rq [$];
    logic [26:0] wq [$];
    int          nb = 0;
    int          cycles = 0;
    int          miscompares = 0;
    int          checks = 0;

    always #20 ref_clk = ~ref_clk;

    smcs_slave u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .pwr_up(pwr_up),
        .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n),
        .so(so), .so_oe(so_oe), .mem_re(mem_re), .mem_raddr(mem_raddr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .mem_ready(mem_ready), .status(status), .mode3(mode3),
        .asleep(asleep), .wbuf_ready(wbuf_ready), .wr_overrun(wr_overrun)
    );

    smcs_host_model u_host (
        .ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n)
    );

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic note(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        note(got === exp, $sformatf("got %h expected %h", got, exp));
    endtask

    task automatic cmp_wr(input logic [26:0] got);
        if (wq.size() == 0)
            note(1'b0, "unexpected array write");
        else
            note(got === wq.pop_front(), $sformatf("write %h", got));
    endtask

    // array model: late read data, random write stalls
    always @(negedge ref_clk) begin
        mem_rvalid <= mem_re;
        mem_rdata <= !mem_re ? ~mem_rdata
                   : mem.exists(mem_raddr) ? mem[mem_raddr] : 8'h5a;
        mem_ready <= !stall && ($urandom_range(0, 3) != 0);
    end

    // output watcher: array writes and serial bytes against the notes
    always @(posedge ref_clk) begin
        cycles++;
        sck_q <= sck;
        if (mem_we && mem_ready) begin
            mem[mem_waddr] = mem_wdata;
            cmp_wr({mem_waddr, mem_wdata});
        end
        if (cs_n)
            nb = 0;
        else if (so_oe && sck && !sck_q) begin
            rx = {rx[6:0], so};
            nb++;
            if (nb == 8) begin
                nb = 0;
                if (rq.size() == 0)
                    note(1'b0, "unexpected serial byte");
                else
                    cmp8(rx, rq.pop_front());
            end
        end
        if (cycles == 60000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic cmd(input logic [7:0] c);
        u_host.frame(1'b0, '{c}, 99);
    endtask

    task automatic rsr(input logic m3, input logic [7:0] e);
        rq.push_back(e);
        u_host.frame(m3, '{8'h05, 8'h00}, 99);
    endtask

    task automatic wr(input logic [18:0] a, input int n,
                      input logic [15:0] ok);
        logic [7:0]  b [$];
        int          j;
        b = '{8'h02, {5'($urandom), a[18:16]}, a[15:8], a[7:0]};
        for (j = 0; j < n; j++) begin
            b.push_back(8'($urandom));
            if (ok[j]) begin
                wq.push_back({a, b[j + 4]});
                shad[a] = b[j + 4];
            end
            a++;
        end
        u_host.frame(1'b0, b, 99);
        repeat (40) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [18:0] a, input int n, input int hb);
        logic [7:0]  b [$];
        int          j;
        b = '{8'h03, {5'($urandom), a[18:16]}, a[15:8], a[7:0]};
        for (j = 0; j < n; j++) begin
            rq.push_back(shad[19'(a + j)]);
            b.push_back(8'($urandom));
        end
        u_host.frame(1'b0, b, hb);
    endtask

    initial begin
        logic [18:0] st [4];
        logic [15:0] okm [4];
        logic [7:0]  v;
        int          i;
        st = '{19'h7ffff, 19'h5ffff, 19'h3ffff, 19'h7ffff};
        okm = '{16'h3, 16'h1, 16'h1, 16'h0};
        void'($urandom(32'h3680));
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmp8(status, 8'h00);
        rsr(1'b0, 8'h00);
        wr(19'h00010, 1, 16'h0);
        cmd(8'h06);
        cmp8(status, 8'h02);
        u_host.frame(1'b0, '{8'h04, 8'h06}, 99);
        cmp8(status, 8'h00);
        cmd(8'h06);
        for (i = 0; i < 4; i++) begin
            v = {1'b0, 3'($urandom), 2'(i), 1'b0, 1'($urandom)};
            u_host.frame(1'b0, '{8'h01, v}, 99);
            rsr(1'b0, v | 8'h02);
            wr(st[i], 2, okm[i]);
        end
        rd(19'h7ffff, 2, 5);
        rsr(1'b1, 8'h02 | v);
        cmp8({7'h0, mode3}, 8'h01);
        u_host.frame(1'b0, '{8'h01, 8'h84}, 99);
        wp_n = 1'b0;
        u_host.frame(1'b0, '{8'h01, 8'h00}, 99);
        rsr(1'b0, 8'h86);
        cmp8({7'h0, mode3}, 8'h00);
        wp_n = 1'b1;
        u_host.frame(1'b0, '{8'h01, 8'h00}, 99);
        rsr(1'b0, 8'h02);
        cmd(8'h04);
        cmp8(status, 8'h00);
        wr(19'h00100, 1, 16'h0);
        cmd(8'h06);
        cmd(8'hb9);
        cmp8({7'h0, asleep}, 8'h01);
        cmd(8'h04);
        u_host.frame(1'b0, '{8'h05, 8'h00}, 99);
        cmp8(status, 8'h02);
        cmd(8'hab);
        repeat (`SMCS_WAKE_CYC) @(negedge ref_clk);
        cmp8({7'h0, asleep}, 8'h00);
        u_host.frame(1'b0, '{8'h01, 8'h71}, 99);
        rsr(1'b0, 8'h73);
        cmd(8'hb9);
        pwr_up = 1'b1;
        @(negedge ref_clk);
        pwr_up = 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp8(status, 8'h71);
        cmp8({7'h0, asleep}, 8'h00);
        cmd(8'h06);
        // frozen clock enable: the clear frame must go unseen
        ce = 1'b0;
        cmd(8'h04);
        ce = 1'b1;
        cmp8(status, 8'h73);
        // far side stalls: buffer fills, late bytes are lost
        stall = 1'b1;
        wr(19'h01000, 11, 16'h7ff);
        cmp8({6'h0, wbuf_ready, wr_overrun}, 8'h01);
        stall = 1'b0;
        repeat (60) @(negedge ref_clk);
        note(wq.size() inside {[1:3]}, "buffer depth");
        wq.delete();
        cmp8({7'h0, wbuf_ready}, 8'h01);
        note(rq.size() == 0 && wq.size() == 0, "notes left over");
        print_verdict();
    end
endmodule // smcs_slave_test
